// ==== rtl/epk_consts.vh ====
// constants for the exit panel keypad programmer: key codes, command digits,
// factory defaults, timing figures and software register offsets
// assumes a 25 MHz system clock and BCD digits packed four bits each
`ifndef EPK_CONSTS_VH
`define EPK_CONSTS_VH
// ************************************************************
// clock and timing
// ************************************************************
`define EPK_CLK_HZ 25000000
`define EPK_KEY_GAP_S 1
`define EPK_TICK_S 1
`define EPK_PRESS_S 3
`define EPK_CONFIRM_S 10
// ************************************************************
// key codes from the keypad scanner
// ************************************************************
`define EPK_KEY_STAR 4'ha
`define EPK_KEY_HASH 4'hb
// ************************************************************
// command digit strings, packed bcd
// ************************************************************
`define EPK_CMD_BASE 36'h987654321
`define EPK_INIT_PRE 12'h603
`define EPK_INIT_CODE 40'h8675309999
`define EPK_LOIT_60 8'h60
`define EPK_LOIT_120 8'h12
`define EPK_LOIT_180 8'h18
// ************************************************************
// factory defaults
// ************************************************************
`define EPK_DEF_PRIM 12'h234
`define EPK_DEF_SEC 12'h567
`define EPK_T15 8'h0f
`define EPK_T30 8'h1e
`define EPK_T60 8'h3c
`define EPK_T120 8'h78
`define EPK_T180 8'hb4
`define EPK_DEF_LOITER_EN 1'b0
`define EPK_DEF_LATCH_EN 1'b0
`define EPK_DEF_ADV_EN 1'b1
`define EPK_DEF_NUIS_EN 1'b0
`define EPK_DEF_SCHED_EN 1'b0
`define EPK_DEF_SCHED_MIN 11'h000
`define EPK_MIN_PER_DAY 11'h59f
// ************************************************************
// software register offsets and flag positions
// ************************************************************
`define EPK_REG_FLAGS 3'h0
`define EPK_REG_TIMES 3'h1
`define EPK_REG_STATUS 3'h2
`define EPK_REG_CLOCK 3'h3
`define EPK_FLG_LOITER 0
`define EPK_FLG_LATCH 1
`define EPK_FLG_ADV 2
`define EPK_FLG_NUIS 3
`define EPK_FLG_SCHED 4
`endif

// ==== rtl/epk_programmer.v ====
// exit panel keypad programmer: key sequence interpreter, settings store,
// weekly arm schedule and door input handling
// assumes key events come from a scanner on clk; door pins are asynchronous
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "epk_consts.vh"
`default_nettype none
module epk_programmer #(
  parameter [26:0] KEY_GAP_CYC = `EPK_KEY_GAP_S * `EPK_CLK_HZ,
  parameter [26:0] SEC_CYC = `EPK_TICK_S * `EPK_CLK_HZ,
  parameter [26:0] PRESS_CYC = `EPK_PRESS_S * `EPK_CLK_HZ
) (
  input wire clk,
  input wire sys_rst,
  input wire nv_blank,
  input wire key_press,
  input wire [3:0] key_code,
  input wire key_hold,
  input wire exit_btn,
  input wire [1:0] egress_sw,
  input wire fire_contact,
  input wire nurse_req,
  input wire [2:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  output wire beep_pulse,
  output wire [3:0] beep_count,
  output wire primary_ok,
  output wire lock_release,
  output wire nurse_alarm,
  output wire escort_active,
  output wire door_beep,
  output wire egress_start,
  output wire sched_disarmed,
  output wire [7:0] entry_time_s,
  output wire [7:0] loiter_time_s,
  output wire [4:0] feature_flags
);
  // ************************************************************
  // parser states
  // ************************************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_FIRST = 3'h1;
  localparam [2:0] ST_CMD = 3'h2;
  localparam [2:0] ST_CODE = 3'h3;
  localparam [2:0] ST_INIT = 3'h4;
  localparam [2:0] ST_SCHED = 3'h5;
  reg [2:0] st_q;
  reg [39:0] buf_q;
  reg [3:0] cnt_q;
  reg [2:0] sub_q;
  reg [2:0] day_sel_q;
  reg [10:0] dis_tmp_q;
  reg code_sel_q;
  reg [26:0] gap_q;
  reg beep_q;
  reg [3:0] beep_n_q;
  reg prim_ok_q;
  // settings, held through sys_rst
  reg [11:0] prim_code_q;
  reg [11:0] sec_code_q;
  reg [7:0] entry_q;
  reg [7:0] loiter_t_q;
  reg [4:0] flags_q;
  reg [10:0] dis_mem [0:6];
  reg [10:0] arm_mem [0:6];
  // time of day
  reg [26:0] div_q;
  reg [5:0] sec_q;
  reg [10:0] now_q;
  reg [2:0] day_q;
  // door side
  reg [2:0] s1_q, s2_q, s3_q, in_q, prev_q;
  reg [7:0] esc_q;
  reg [26:0] press_q;
  reg pressing_q, door_beep_q, egress_q, lock_q, nurse_q, disarm_q;
  wire sec_tick = (div_q == SEC_CYC - 27'h1);
  wire [39:0] buf_nx = {buf_q[35:0], key_code};
  wire [3:0] cnt_nx = cnt_q + 4'h1;
  wire is_digit = (key_code <= 4'h9);
  wire [2:0] today = day_q - 3'h1;
  wire [2:0] sel_idx = day_sel_q - 3'h1;
  integer i;
  // bcd hhmm to minutes after midnight; out-of-range entries are not trapped
  function [10:0] hhmm_min;
    input [15:0] b;
    begin
      hhmm_min = {7'h00, b[15:12]} * 11'h258 + {7'h00, b[11:8]} * 11'h03c +
                 {7'h00, b[7:4]} * 11'h00a + {7'h00, b[3:0]};
    end
  endfunction
  // factory values for every stored setting
  task load_defaults;
    begin
      prim_code_q <= `EPK_DEF_PRIM;
      sec_code_q <= `EPK_DEF_SEC;
      entry_q <= `EPK_T30;
      loiter_t_q <= `EPK_T60;
      flags_q[`EPK_FLG_LOITER] <= `EPK_DEF_LOITER_EN;
      flags_q[`EPK_FLG_LATCH] <= `EPK_DEF_LATCH_EN;
      flags_q[`EPK_FLG_ADV] <= `EPK_DEF_ADV_EN;
      flags_q[`EPK_FLG_NUIS] <= `EPK_DEF_NUIS_EN;
      flags_q[`EPK_FLG_SCHED] <= `EPK_DEF_SCHED_EN;
      for (i = 0; i < 7; i = i + 1) begin
        dis_mem[i] <= `EPK_DEF_SCHED_MIN;
        arm_mem[i] <= `EPK_DEF_SCHED_MIN;
      end
    end
  endtask
  // one confirmation burst request
  task beep;
    input [3:0] n;
    begin
      beep_q <= 1'b1;
      beep_n_q <= n;
    end
  endtask
  // ************************************************************
  // key sequence interpreter, settings store and clock
  // ************************************************************
  always @(posedge clk) begin
    beep_q <= 1'b0;
    prim_ok_q <= 1'b0;
    if (sys_rst) begin
      st_q <= ST_IDLE;
      buf_q <= 40'h0;
      cnt_q <= 4'h0;
      sub_q <= 3'h0;
      day_sel_q <= 3'h0;
      dis_tmp_q <= 11'h0;
      code_sel_q <= 1'b0;
      gap_q <= 27'h0;
      beep_n_q <= 4'h0;
      div_q <= 27'h0;
      sec_q <= 6'h0;
      now_q <= 11'h0;
      day_q <= 3'h1;
      // storage keeps its contents unless it was never written
      if (nv_blank) begin
        load_defaults;
      end
    end else begin
      // free running time of day
      if (sec_tick) begin
        div_q <= 27'h0;
        if (sec_q == 6'h3b) begin
          sec_q <= 6'h0;
          if (now_q == `EPK_MIN_PER_DAY) begin
            now_q <= 11'h0;
            day_q <= (day_q == 3'h7) ? 3'h1 : day_q + 3'h1;
          end else begin
            now_q <= now_q + 11'h1;
          end
        end else begin
          sec_q <= sec_q + 6'h1;
        end
      end else begin
        div_q <= div_q + 27'h1;
      end
      // software write to the feature flags
      if (reg_wr && reg_addr == `EPK_REG_FLAGS) begin
        flags_q <= reg_wdata[4:0];
      end
      if (key_press || key_hold) begin
        gap_q <= 27'h0;
        case (st_q)
          ST_IDLE: begin
            if (key_press && key_code == `EPK_KEY_STAR) begin
              st_q <= ST_FIRST;
              buf_q <= 40'h0;
              cnt_q <= 4'h0;
            end
          end
          ST_FIRST: begin
            if (key_press && key_code == `EPK_KEY_STAR) begin
              buf_q <= 40'h0;
              cnt_q <= 4'h0;
              if (cnt_q == 4'h3 && buf_q[11:0] == sec_code_q) begin
                st_q <= ST_CMD;
              end else if (cnt_q == 4'h3 && buf_q[11:0] == `EPK_INIT_PRE) begin
                st_q <= ST_INIT;
              end else begin
                st_q <= ST_FIRST;
              end
            end else if (key_press && is_digit && cnt_q < 4'h3) begin
              buf_q <= buf_nx;
              cnt_q <= cnt_nx;
              if (cnt_q == 4'h2 && buf_nx[11:0] == prim_code_q) begin
                prim_ok_q <= 1'b1;
              end
            end else if (key_press) begin
              st_q <= ST_IDLE;
            end
          end
          ST_CMD: begin
            if (key_press && is_digit && cnt_q < 4'ha) begin
              buf_q <= buf_nx;
              cnt_q <= cnt_nx;
              // two-digit loiter time codes act on the second press
              if (cnt_q == 4'h1 && buf_q[3:0] != 4'h9) begin
                st_q <= ST_IDLE;
                if (buf_nx[7:0] == `EPK_LOIT_60) begin
                  loiter_t_q <= `EPK_T60;
                  beep(4'h1);
                end else if (buf_nx[7:0] == `EPK_LOIT_120) begin
                  loiter_t_q <= `EPK_T120;
                  beep(4'h2);
                end else if (buf_nx[7:0] == `EPK_LOIT_180) begin
                  loiter_t_q <= `EPK_T180;
                  beep(4'h3);
                end
              end
            end else if (key_press && key_code == `EPK_KEY_HASH && cnt_q == 4'ha &&
                         buf_q[39:4] == `EPK_CMD_BASE && buf_q[3:1] == 3'h0) begin
              st_q <= ST_CODE;
              code_sel_q <= buf_q[0];
              buf_q <= 40'h0;
              cnt_q <= 4'h0;
            end else if (key_press) begin
              st_q <= ST_IDLE;
            end else if (cnt_q == 4'h1) begin
              st_q <= ST_IDLE;
              case (buf_q[3:0])
                4'h1: begin entry_q <= `EPK_T15; beep(4'h1); end
                4'h2: begin entry_q <= `EPK_T30; beep(4'h1); end
                4'h3: begin entry_q <= `EPK_T60; beep(4'h1); end
                4'h4: begin entry_q <= `EPK_T120; beep(4'h1); end
                4'h5: begin
                  flags_q[`EPK_FLG_LOITER] <= ~flags_q[`EPK_FLG_LOITER];
                  beep(flags_q[`EPK_FLG_LOITER] ? 4'h1 : 4'h4);
                end
                4'h0: begin
                  flags_q[`EPK_FLG_LATCH] <= ~flags_q[`EPK_FLG_LATCH];
                  beep(flags_q[`EPK_FLG_LATCH] ? 4'h1 : 4'h4);
                end
                4'h7: begin flags_q[`EPK_FLG_SCHED] <= 1'b1; beep(4'h4); end
                4'h8: begin flags_q[`EPK_FLG_SCHED] <= 1'b0; beep(4'h1); end
                default: begin end
              endcase
            end else if (cnt_q == 4'ha && buf_q[39:4] == `EPK_CMD_BASE) begin
              st_q <= ST_IDLE;
              case (buf_q[3:0])
                4'h6: begin
                  flags_q[`EPK_FLG_ADV] <= ~flags_q[`EPK_FLG_ADV];
                  beep(flags_q[`EPK_FLG_ADV] ? 4'h1 : 4'h2);
                end
                4'h2: begin flags_q[`EPK_FLG_NUIS] <= 1'b1; beep(4'h2); end
                4'h3: begin flags_q[`EPK_FLG_NUIS] <= 1'b0; beep(4'h4); end
                4'h1: begin
                  st_q <= ST_SCHED;
                  sub_q <= 3'h0;
                  cnt_q <= 4'h0;
                  beep(4'h1);
                end
                default: begin end
              endcase
            end else begin
              st_q <= ST_IDLE;
            end
          end
          ST_CODE: begin
            if (key_press && is_digit && cnt_q < 4'h3) begin
              buf_q <= buf_nx;
              cnt_q <= cnt_nx;
            end else if (key_press && key_code == `EPK_KEY_HASH && cnt_q == 4'h3) begin
              st_q <= ST_IDLE;
              beep(4'h1);
              if (code_sel_q) begin
                sec_code_q <= buf_q[11:0];
              end else begin
                prim_code_q <= buf_q[11:0];
              end
            end else if (key_press) begin
              st_q <= ST_IDLE;
            end
          end
          ST_INIT: begin
            if (key_press && is_digit) begin
              buf_q <= buf_nx;
              cnt_q <= cnt_nx;
              if (cnt_q == 4'h9) begin
                st_q <= ST_IDLE;
                if (buf_nx == `EPK_INIT_CODE) begin
                  load_defaults;
                  beep(4'h9);
                end
              end
            end else if (key_press) begin
              st_q <= ST_IDLE;
            end
          end
          ST_SCHED: begin
            // confirmations are issued at once, well inside the allowed delay
            if (key_press && key_code == `EPK_KEY_STAR) begin
              st_q <= ST_IDLE;
              beep(4'h4);
            end else if (key_press && is_digit) begin
              case (sub_q)
                3'h0: begin
                  if (key_code >= 4'h1 && key_code <= 4'h7) begin
                    day_q <= key_code[2:0];
                    sub_q <= 3'h1;
                    cnt_q <= 4'h0;
                    beep(4'h2);
                  end
                end
                3'h2: begin
                  if (key_code <= 4'h7) begin
                    day_sel_q <= key_code[2:0];
                    sub_q <= 3'h3;
                    cnt_q <= 4'h0;
                    beep(4'h1);
                  end
                end
                default: begin
                  buf_q <= buf_nx;
                  cnt_q <= cnt_nx;
                  if (cnt_q == 4'h3) begin
                    cnt_q <= 4'h0;
                    if (sub_q == 3'h1) begin
                      now_q <= hhmm_min(buf_nx[15:0]);
                      sec_q <= 6'h0;
                      div_q <= 27'h0;
                      sub_q <= 3'h2;
                      beep(4'h3);
                    end else if (sub_q == 3'h3) begin
                      dis_tmp_q <= hhmm_min(buf_nx[15:0]);
                      sub_q <= 3'h4;
                      beep(4'h2);
                    end else begin
                      sub_q <= 3'h2;
                      beep(4'h3);
                      for (i = 0; i < 7; i = i + 1) begin
                        if (day_sel_q == 3'h0 || sel_idx == i[2:0]) begin
                          dis_mem[i] <= dis_tmp_q;
                          arm_mem[i] <= hhmm_min(buf_nx[15:0]);
                        end
                      end
                    end
                  end
                end
              endcase
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end else if (st_q != ST_IDLE) begin
        // a silent pause drops whatever has been typed
        if (gap_q == KEY_GAP_CYC - 27'h1) begin
          st_q <= ST_IDLE;
          gap_q <= 27'h0;
        end else begin
          gap_q <= gap_q + 27'h1;
        end
      end
    end
  end
  // ************************************************************
  // door inputs and outputs
  // ************************************************************
  // three-stage sync; a level is taken when stages two and three agree
  always @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      s3_q <= 3'h0;
      in_q <= 3'h0;
      prev_q <= 3'h0;
    end else begin
      s1_q <= {fire_contact, egress_sw[1] | egress_sw[0], exit_btn};
      s2_q <= s1_q;
      s3_q <= s2_q;
      in_q <= (s2_q & s3_q) | (in_q & (s2_q ^ s3_q));
      prev_q <= in_q;
    end
  end
  // escort, door pressure, lock and nurse alarm
  always @(posedge clk) begin
    egress_q <= 1'b0;
    if (sys_rst) begin
      esc_q <= 8'h0;
      press_q <= 27'h0;
      pressing_q <= 1'b0;
      door_beep_q <= 1'b0;
      lock_q <= 1'b0;
      nurse_q <= 1'b0;
      disarm_q <= 1'b0;
    end else begin
      // countdown resolution is one second tick, so the first second may be short
      if ((in_q[0] && !prev_q[0]) || prim_ok_q) begin
        esc_q <= entry_q;
      end else if (sec_tick && esc_q != 8'h0) begin
        esc_q <= esc_q - 8'h1;
      end
      if (in_q[1] && !prev_q[1]) begin
        press_q <= 27'h0;
        pressing_q <= 1'b1;
        door_beep_q <= ~flags_q[`EPK_FLG_NUIS];
        egress_q <= flags_q[`EPK_FLG_NUIS];
      end else if (!in_q[1]) begin
        pressing_q <= 1'b0;
        door_beep_q <= 1'b0;
      end else if (door_beep_q && flags_q[`EPK_FLG_NUIS]) begin
        // silencing switched on mid-press: stop the noise and go straight to egress
        door_beep_q <= 1'b0;
        egress_q <= 1'b1;
      end else if (pressing_q && door_beep_q) begin
        if (press_q == PRESS_CYC - 27'h1) begin
          door_beep_q <= 1'b0;
          egress_q <= 1'b1;
        end else begin
          press_q <= press_q + 27'h1;
        end
      end
      lock_q <= in_q[2] | (esc_q != 8'h0);
      nurse_q <= nurse_req & ~in_q[2];
      disarm_q <= flags_q[`EPK_FLG_SCHED] && now_q >= dis_mem[today] && now_q < arm_mem[today];
    end
  end
  // ************************************************************
  // register read port
  // ************************************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        `EPK_REG_FLAGS: reg_rdata <= {11'h0, flags_q};
        `EPK_REG_TIMES: reg_rdata <= {entry_q, loiter_t_q};
        `EPK_REG_STATUS: reg_rdata <= {7'h0, st_q, disarm_q, in_q, lock_q, esc_q != 8'h0};
        `EPK_REG_CLOCK: reg_rdata <= {2'h0, day_q, now_q};
        default: reg_rdata <= 16'h0;
      endcase
    end else begin
      reg_rdata <= 16'h0;
    end
  end
  assign beep_pulse = beep_q;
  assign beep_count = beep_n_q;
  assign primary_ok = prim_ok_q;
  assign lock_release = lock_q;
  assign nurse_alarm = nurse_q;
  assign escort_active = (esc_q != 8'h0);
  assign door_beep = door_beep_q;
  assign egress_start = egress_q;
  assign sched_disarmed = disarm_q;
  assign entry_time_s = entry_q;
  assign loiter_time_s = loiter_t_q;
  assign feature_flags = flags_q;
endmodule // epk_programmer
`default_nettype wire

// ==== test/epk_programmer_monitor.sv ====
// port checker for the exit panel keypad programmer
// assumes one clk domain and the synchronous reset sys_rst
`timescale 1ns/1ps
`default_nettype none
module epk_programmer_monitor (
  input wire clk,
  input wire sys_rst,
  input wire key_press,
  input wire key_hold,
  input wire exit_btn,
  input wire [1:0] egress_sw,
  input wire fire_contact,
  input wire [2:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire beep_pulse,
  input wire lock_release,
  input wire nurse_alarm,
  input wire escort_active,
  input wire door_beep,
  input wire sched_disarmed,
  input wire [7:0] entry_time_s,
  input wire [7:0] loiter_time_s,
  input wire [4:0] feature_flags
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // pins pass a sync chain, so causes must stand a few cycles
  sequence fire_held; fire_contact [*8]; endsequence
  sequence press_held; ($rose(egress_sw != 2'h0) && !feature_flags[3]) ##1 (egress_sw != 2'h0) [*6]; endsequence
  chk_fire_release: assert property (fire_held |-> lock_release)
    else $error("lock not released in fire");
  chk_fire_nurse: assert property (fire_held |-> !nurse_alarm)
    else $error("nurse alarm during fire");
  chk_exit_escort: assert property ($rose(exit_btn) ##1 exit_btn [*6] |-> escort_active)
    else $error("exit button gave no escort");
  chk_press_beep: assert property (press_held |-> door_beep)
    else $error("door pressure gave no beep");
  chk_silent_door: assert property (feature_flags[3] && $past(feature_flags[3]) |-> !door_beep)
    else $error("door beep while silenced");
  chk_beep_cause: assert property (beep_pulse |-> $past(key_press || key_hold))
    else $error("beep without key event");
  chk_flag_cause: assert property ($changed(feature_flags) |-> beep_pulse || $past(reg_wr && reg_addr == 3'h0))
    else $error("flags changed without command");
  chk_entry_range: assert property (entry_time_s inside {8'h0f, 8'h1e, 8'h3c, 8'h78})
    else $error("entry time out of set");
  chk_loiter_range: assert property (loiter_time_s inside {8'h3c, 8'h78, 8'hb4})
    else $error("loiter time out of set");
  chk_sched_gate: assert property (!feature_flags[4] && !$past(feature_flags[4]) |-> !sched_disarmed)
    else $error("disarmed with schedule off");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
    else $error("read data outside read slot");
endmodule // epk_programmer_monitor
bind epk_programmer epk_programmer_monitor i_epk_programmer_monitor (.*);
`default_nettype wire

// ==== test/epk_user_model.sv ====
// keypad user, door switches and fire relay facing the programmer
// assumes the bench seeds the random source before use
`timescale 1ns/1ps
`default_nettype none
module epk_user_model (
  input wire logic clk,
  output logic key_press,
  output logic [3:0] key_code,
  output logic key_hold,
  output logic exit_btn,
  output logic [1:0] egress_sw,
  output logic fire_contact
);
  // ****
  // keystrokes and pins
  // ****
  initial {key_press, key_code, key_hold, exit_btn, egress_sw, fire_contact} = 10'h0;
  // code is inverted once the press is gone so no stale key is seen
  task automatic keys(input logic [79:0] s, input int n, input bit hold);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      key_press <= 1'b1;
      key_code <= s[i*4 +: 4];
      @(posedge clk);
      key_press <= 1'b0;
      key_code <= ~s[i*4 +: 4];
      repeat ($urandom_range(3, 0)) @(posedge clk);
    end
    if (hold) begin
      @(posedge clk);
      key_hold <= 1'b1;
      @(posedge clk);
      key_hold <= 1'b0;
    end
  endtask
  task automatic pins(input logic e, input logic [1:0] g, input logic f);
    @(posedge clk);
    exit_btn <= e;
    egress_sw <= g;
    fire_contact <= f;
  endtask
endmodule // epk_user_model
`default_nettype wire

// ==== test/tb_epk_programmer.sv ====
// self-checking bench for the exit panel keypad programmer
// assumes the user model drives keys and pins; short counts for speed
`timescale 1ns/1ps
`default_nettype none
module tb_epk_programmer;
  logic clk = 1'b0, sys_rst = 1'b1, nv_blank = 1'b1, nurse_req = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0, reg_rdata, rd;
  logic key_press, key_hold, exit_btn, fire_contact, beep_pulse, primary_ok, lock_release, nurse_alarm;
  logic escort_active, door_beep, egress_start, sched_disarmed;
  logic [3:0] key_code, beep_count, lastb;
  logic [1:0] egress_sw;
  logic [7:0] entry_time_s, loiter_time_s;
  logic [4:0] feature_flags, ef = 5'h04;
  logic [11:0] sec = 12'h567, x, p;
  int miscompares = 0, checks = 0, nb = 0, nok = 0, neg = 0, t;
  always #20 clk = ~clk;
  epk_programmer #(.KEY_GAP_CYC(27'd50), .SEC_CYC(27'd20), .PRESS_CYC(27'd30)) i_epk_programmer (.*);
  epk_user_model i_epk_user_model (.*);
  // ****
  // tasks
  // ****
  // pulses are one cycle wide, so they are counted as they pass
  always @(posedge clk) begin
    if (beep_pulse) begin
      nb <= nb + 1;
      lastb <= beep_count;
    end
    if (primary_ok) nok <= nok + 1;
    if (egress_start) neg <= neg + 1;
  end
  task automatic print_verdict;
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  function automatic logic [11:0] bcd(input int v);
    return {4'(v / 100), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction
  task automatic bus(input logic w, input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    {reg_wr, reg_rd} <= 2'b00;
    #1 rd = reg_rdata;
  endtask
  task automatic send(input logic [79:0] s, input int n, input bit h, input int np, input int eb);
    nb = 0;
    i_epk_user_model.keys(s, n, h);
    repeat (3) @(posedge clk);
    check("beeps", {nb[27:0], np ? lastb : 4'h0}, {np[27:0], 4'(eb)});
  endtask
  task automatic cmd(input logic [59:0] c, input int n, input bit h, input int eb);
    send(({60'h0, 4'ha, sec, 4'ha} << (4 * n)) | c, n + 5, h, eb != 0, eb);
  endtask
  task automatic fl(input logic [59:0] c, input int n, input int eb, input int b, input logic v);
    ef[b] = v;
    cmd(c, n, 1, eb);
    check("flags", feature_flags, ef);
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    print_verdict;
  end
  // ****
  // main sequence
  // ****
  initial begin
    t = $urandom(32'hedb89254);
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    nv_blank <= 1'b0;
    bus(0, 3'h1, 16'h0);
    check("times", rd, 16'h1e3c);
    bus(0, 3'h6, 16'h0);
    check("unmapped", rd, 16'h0);
    for (t = 1; t <= 4; t++) begin
      cmd(t, 1, 1, 1);
      check("entry", entry_time_s, 15 << (t - 1));
    end
    for (t = 0; t < 3; t++) begin
      cmd(t == 0 ? 60'h12 : t == 1 ? 60'h18 : 60'h60, 2, 0, (t + 1) % 3 + 1);
      check("loiter", loiter_time_s, 60 * ((t + 1) % 3 + 1));
    end
    fl(60'h5, 1, 4, 0, 1);
    fl(60'h5, 1, 1, 0, 0);
    fl(60'h0, 1, 4, 1, 1);
    fl(60'h0, 1, 1, 1, 0);
    fl(60'h9876543216, 10, 1, 2, 0);
    fl(60'h9876543216, 10, 2, 2, 1);
    fl(60'h9876543212, 10, 2, 3, 1);
    fl(60'h9876543213, 10, 4, 3, 0);
    cmd(60'h33, 2, 0, 0);
    do t = $urandom_range(999, 0); while (t == 567 || t == 603 || t == 234);
    x = bcd(t);
    cmd({40'h9876543211, 4'hb, x, 4'hb}, 15, 0, 1);
    cmd(60'h5, 1, 1, 0);
    check("flags", feature_flags, ef);
    sec = x;
    fl(60'h5, 1, 4, 0, 1);
    do t = $urandom_range(999, 0); while (bcd(t) == x || t == 603);
    p = bcd(t);
    cmd({40'h9876543210, 4'hb, p, 4'hb}, 15, 0, 1);
    nok = 0;
    i_epk_user_model.keys({64'h0, 4'ha, p}, 4, 0);
    repeat (3) @(posedge clk);
    check("primary", nok, 1);
    check("escort", escort_active, 1);
    // clock set to day 3 14:03, all days disarmed 00:00 to 23:59
    cmd(60'h9876543211, 10, 1, 1);
    send(80'h3, 1, 0, 1, 2);
    send(80'h1403, 4, 0, 1, 3);
    send(80'h0, 1, 0, 1, 1);
    send(80'h0000, 4, 0, 1, 2);
    send(80'h2359, 4, 0, 1, 3);
    send(80'ha, 1, 0, 1, 4);
    fl(60'h7, 1, 4, 4, 1);
    check("disarmed", sched_disarmed, 1);
    bus(0, 3'h3, 16'h0);
    check("clock", rd[13:0], {3'h3, 11'h34b});
    cmd(60'h9876543211, 10, 1, 1);
    send(80'h31403, 5, 0, 2, 3);
    send(80'h315001600, 9, 0, 3, 3);
    send(80'ha, 1, 0, 1, 4);
    check("disarmed", sched_disarmed, 0);
    fl(60'h8, 1, 1, 4, 0);
    i_epk_user_model.pins(0, 2'b10, 0);
    repeat (10) @(posedge clk);
    check("door_beep", door_beep, 1);
    neg = 0;
    repeat (40) @(posedge clk);
    check("egress", neg, 1);
    i_epk_user_model.pins(0, 2'b00, 0);
    fl(60'h9876543212, 10, 2, 3, 1);
    neg = 0;
    i_epk_user_model.pins(0, 2'b01, 0);
    repeat (10) @(posedge clk);
    check("silent", {door_beep, neg[3:0]}, 5'h01);
    i_epk_user_model.pins(0, 2'b00, 0);
    cmd(60'h1, 1, 1, 1);
    repeat (2500) @(posedge clk);
    i_epk_user_model.pins(1, 2'b00, 0);
    repeat (8) @(posedge clk);
    check("escort", escort_active, 1);
    i_epk_user_model.pins(0, 2'b00, 0);
    repeat (330) @(posedge clk);
    check("escort end", escort_active, 0);
    // escort is over, so the lock only opens for the fire contact here
    nurse_req <= 1'b1;
    repeat (2) @(posedge clk);
    check("nurse", {lock_release, nurse_alarm}, 2'b01);
    i_epk_user_model.pins(0, 2'b00, 1);
    repeat (10) @(posedge clk);
    check("fire", {lock_release, nurse_alarm}, 2'b10);
    i_epk_user_model.pins(0, 2'b00, 0);
    nurse_req <= 1'b0;
    bus(1, 3'h1, 16'($urandom));
    bus(0, 3'h1, 16'h0);
    check("times", rd, 16'h0f3c);
    ef = 5'($urandom);
    bus(1, 3'h0, {11'h0, ef});
    bus(0, 3'h0, 16'h0);
    check("flags", rd, {11'h0, ef});
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    bus(0, 3'h0, 16'h0);
    check("kept", rd, {11'h0, ef});
    send(80'ha603a8675309999, 15, 0, 1, 9);
    bus(0, 3'h1, 16'h0);
    check("times", {rd, 11'h0, feature_flags}, {16'h1e3c, 16'h0004});
    print_verdict;
  end
endmodule // tb_epk_programmer
`default_nettype wire
